/* File: rtl/curtain_pkg.sv */
// package: constants, types and timing for the light curtain sequencer
package curtain_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned STOP_MAX_MS     = 30;
  localparam int unsigned STOP_MAX_CYC    = STOP_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned OVR_HOLD_S      = 3;
  localparam int unsigned OVR_MAX_S       = 12;
  localparam int unsigned OVR_HOLD_CYC    = OVR_HOLD_S * CLK_HZ;
  localparam int unsigned OVR_MAX_CYC     = OVR_MAX_S * CLK_HZ;
  localparam int unsigned SLOW_HZ         = 1;
  localparam int unsigned FAST_HZ         = 3;
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / (2 * SLOW_HZ);
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / (2 * FAST_HZ);
  localparam int unsigned MUTE_STEPS      = 10;
  localparam logic [3:0]  MUTE_UNLIMITED  = 4'h9;
  localparam logic [3:0]  FN_PROT_LO      = 4'h0;
  localparam logic [3:0]  FN_PROT_HI      = 4'h1;
  localparam logic [3:0]  FN_MUTE_LO      = 4'h2;
  localparam logic [3:0]  FN_MUTE_HI      = 4'h5;
  localparam logic [3:0]  SUB_FB_LO       = 4'h5;
  localparam logic [3:0]  SUB_BAD_A       = 4'h0;
  localparam logic [3:0]  SUB_BAD_B       = 4'h4;
  localparam logic [3:0]  SUB_BAD_C       = 4'h9;
  localparam logic [2:0]  CODE_NONE       = 3'h0;
  localparam logic [2:0]  CODE_CURTAIN    = 3'h1;
  localparam logic [2:0]  CODE_VOLT       = 3'h2;
  localparam logic [2:0]  CODE_MUTE       = 3'h4;
  localparam logic [2:0]  CODE_CONFIG     = 3'h5;
  localparam logic [3:0]  PAUSE_SLOTS     = 4'h4;

  typedef struct packed {
    logic [3:0] func;
    logic [3:0] sub;
  } selector_t;

  typedef struct packed {
    logic relay_a;
    logic relay_b;
    logic led_relay_a;
    logic led_relay_b;
    logic led_ch1;
    logic led_ch2;
    logic fault_lamp;
    logic wait_lamp;
  } indic_t;

  typedef enum logic [2:0] {ST_WAIT, ST_RUN, ST_BLOCK, ST_MUTE, ST_OVR, ST_SPECIAL}
    run_state_t;
endpackage

/* File: rtl/light_curtain_safety_sequencer.sv */
// light curtain safety sequencer: starts, muting, override and indication
module light_curtain_safety_sequencer
  import curtain_pkg::*;
#(
  parameter int unsigned MUTE_BASE_CYC = 10 * 100_000_000
) (
  // clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  // configuration
  input  wire curtain_pkg::selector_t sel_in,
  // field inputs, curtain high means clear
  input  wire logic [2:0]         curtain_clear_in,
  input  wire logic [3:0]         mute_sensor_in,
  input  wire logic               start_btn_in,
  input  wire logic               feedback_closed_in,
  input  wire logic               mute_lamp_ok_in,
  input  wire logic               undervolt_in,
  input  wire logic               overvolt_in,
  // outputs
  output curtain_pkg::indic_t     ind_out,
  output logic                    mute_lamp_out
);
  import curtain_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  run_state_t  state_q;
  logic [2:0]  manual_q;
  logic        fb_en_q;
  logic        cfg_bad_q;
  logic        muting_q;
  logic        four_q;
  logic [2:0]  prev_clear_q;
  logic        btn_prev_q;
  logic [2:0]  code_q;
  logic [1:0]  seq_q;
  logic [31:0] mute_cnt_q;
  logic [31:0] hold_cnt_q;
  logic [31:0] ovr_cnt_q;
  logic [31:0] slow_cnt_q;
  logic [31:0] fast_cnt_q;
  logic        slow_tgl_q;
  logic        fast_tgl_q;
  logic [3:0]  slot_q;
  logic        code_phase_q;
  logic        code_lit_q;

  // muting time limit in base units; a simple doubling ladder stands in for the table
  function automatic logic [31:0] mute_limit(input logic [3:0] sub);
    logic [31:0] m;
    m = MUTE_BASE_CYC;
    mute_limit = m << sub[2:0];
  endfunction

  function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo,
                                    input logic [3:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode, registered so the outputs never see a glitch
  logic mute_sel;
  logic prot_sel;
  logic special;
  logic btn_rise;
  logic any_manual_blocked;
  assign mute_sel = in_range(sel_in.func, FN_MUTE_LO, FN_MUTE_HI);
  assign prot_sel = in_range(sel_in.func, FN_PROT_LO, FN_PROT_HI);
  assign special  = undervolt_in || overvolt_in;
  assign btn_rise = start_btn_in && !btn_prev_q;
  assign any_manual_blocked = |(manual_q & ~curtain_clear_in);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      manual_q  <= 3'h7;
      fb_en_q   <= 1'b0;
      cfg_bad_q <= 1'b0;
      muting_q  <= 1'b0;
      four_q    <= 1'b0;
    end else begin
      muting_q <= mute_sel;
      four_q   <= sel_in.func[1] == 1'b0 && mute_sel;
      if (mute_sel) begin
        manual_q  <= {2'b11, sel_in.func[0]};
        fb_en_q   <= 1'b0;
        cfg_bad_q <= 1'b0;
      end else begin
        // sub 1..3 / 6..8 pick how many curtains run automatic
        manual_q[0] <= sel_in.func[0];
        manual_q[1] <= !((sel_in.sub == 4'h2) || (sel_in.sub == 4'h3) ||
                         (sel_in.sub == 4'h7) || (sel_in.sub == 4'h8));
        manual_q[2] <= !((sel_in.sub == 4'h3) || (sel_in.sub == 4'h8));
        fb_en_q     <= sel_in.sub >= SUB_FB_LO;
        cfg_bad_q   <= !prot_sel || (sel_in.sub == SUB_BAD_A) ||
                       (sel_in.sub == SUB_BAD_B) || (sel_in.sub >= SUB_BAD_C);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_clear_q <= 3'h0;
      btn_prev_q   <= 1'b0;
    end else begin
      prev_clear_q <= curtain_clear_in;
      btn_prev_q   <= start_btn_in;
    end
  end

  logic manual_trip_q; // a manual break owes a start even if it was brief
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      manual_trip_q <= 1'b0;
    end else if (any_manual_blocked) begin
      manual_trip_q <= 1'b1;
    end else if (state_q == ST_RUN) begin
      manual_trip_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // muting sequence: sensors A..B (then C) must rise before the curtain breaks
  logic seq_ok;
  assign seq_ok = (seq_q == 2'h3);
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_q <= 2'h0;
    end else if (state_q != ST_RUN || !muting_q) begin
      seq_q <= 2'h0;
    end else if (mute_sensor_in[0] && seq_q == 2'h0) begin
      seq_q <= 2'h1;
    end else if (mute_sensor_in[1] && mute_sensor_in[0] && seq_q == 2'h1) begin
      seq_q <= four_q ? 2'h2 : 2'h3;
    end else if (four_q && mute_sensor_in[2] && seq_q == 2'h2) begin
      seq_q <= 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequencer; each curtain, muting or voltage stop changes state_q in one cycle and opens the relays one cycle later, well inside the stop budget
  logic mute_pair;
  assign mute_pair = mute_sensor_in[0] && mute_sensor_in[1];
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_WAIT;
      code_q  <= CODE_NONE;
    end else if (special) begin
      state_q <= ST_SPECIAL;
      code_q  <= CODE_VOLT;
    end else if (cfg_bad_q) begin
      state_q <= ST_BLOCK;
      code_q  <= CODE_CONFIG;
    end else begin
      case (state_q)
        ST_SPECIAL: begin
          state_q <= ST_WAIT;
          code_q  <= CODE_NONE;
        end
        ST_WAIT: begin
          if (&curtain_clear_in && (!fb_en_q || feedback_closed_in) &&
              (!muting_q || mute_lamp_ok_in) && (btn_rise || manual_q == 3'h0)) begin
            state_q <= ST_RUN;
            code_q  <= CODE_NONE;
          end
        end
        ST_RUN: begin
          if (muting_q && !curtain_clear_in[0] && &curtain_clear_in[2:1] && seq_ok) begin
            state_q <= ST_MUTE;
          end else if (!(&curtain_clear_in)) begin
            state_q <= ST_BLOCK;
            code_q  <= CODE_CURTAIN;
          end
        end
        ST_MUTE: begin
          if (!(&curtain_clear_in[2:1])) begin
            state_q <= ST_BLOCK;
            code_q  <= CODE_CURTAIN;
          end else if ((sel_in.sub != MUTE_UNLIMITED) &&
                       (mute_cnt_q >= mute_limit(sel_in.sub))) begin
            state_q <= ST_BLOCK;
            code_q  <= CODE_MUTE;
          end else if (!mute_pair && !curtain_clear_in[0]) begin
            state_q <= ST_BLOCK;
            code_q  <= CODE_MUTE;
          end else if (curtain_clear_in[0] && !mute_pair) begin
            state_q <= ST_RUN;
          end
        end
        ST_BLOCK: begin
          if (muting_q && mute_pair && !curtain_clear_in[0] && &curtain_clear_in[2:1] &&
              hold_cnt_q >= OVR_HOLD_CYC) begin
            state_q <= ST_OVR;
          end else if (btn_rise && &curtain_clear_in &&
                       (!muting_q || mute_lamp_ok_in) && (!fb_en_q || feedback_closed_in)) begin
            state_q <= ST_RUN;
            code_q  <= CODE_NONE;
          end else if (!manual_trip_q && (!muting_q || mute_lamp_ok_in) &&
                       code_q == CODE_CURTAIN && &curtain_clear_in) begin
            state_q <= ST_RUN;
            code_q  <= CODE_NONE;
          end
        end
        ST_OVR: begin
          if (!start_btn_in || !(mute_sensor_in[0] || mute_sensor_in[1]) ||
              ovr_cnt_q >= OVR_MAX_CYC) begin
            state_q <= ST_BLOCK;
          end
        end
        default: state_q <= ST_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mute_cnt_q <= 32'h0000_0000;
    end else if (state_q == ST_MUTE) begin
      mute_cnt_q <= mute_cnt_q + 32'h0000_0001;
    end else begin
      mute_cnt_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_cnt_q <= 32'h0000_0000;
      ovr_cnt_q  <= 32'h0000_0000;
    end else begin
      hold_cnt_q <= (start_btn_in && state_q == ST_BLOCK) ? hold_cnt_q + 32'h0000_0001
                                                           : 32'h0000_0000;
      ovr_cnt_q  <= (state_q == ST_OVR) ? ovr_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // flash bases; codes count slots of the slow blinker so bursts stay readable
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slow_cnt_q <= 32'h0000_0000;
      fast_cnt_q <= 32'h0000_0000;
      slow_tgl_q <= 1'b0;
      fast_tgl_q <= 1'b0;
    end else begin
      slow_cnt_q <= (slow_cnt_q >= SLOW_HALF_CYC - 1) ? 32'h0000_0000
                                                       : slow_cnt_q + 32'h0000_0001;
      fast_cnt_q <= (fast_cnt_q >= FAST_HALF_CYC - 1) ? 32'h0000_0000
                                                       : fast_cnt_q + 32'h0000_0001;
      if (slow_cnt_q >= SLOW_HALF_CYC - 1) slow_tgl_q <= !slow_tgl_q;
      if (fast_cnt_q >= FAST_HALF_CYC - 1) fast_tgl_q <= !fast_tgl_q;
    end
  end

  // code burst: code flashes, then a dark pause of several slots
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_q       <= 4'h0;
      code_phase_q <= 1'b0;
      code_lit_q   <= 1'b0;
    end else if (slow_cnt_q >= SLOW_HALF_CYC - 1) begin
      code_phase_q <= !code_phase_q;
      if (code_phase_q) begin
        slot_q <= (slot_q >= {1'b0, code_q} + PAUSE_SLOTS - 4'h1) ? 4'h0 : slot_q + 4'h1;
      end
      code_lit_q <= !code_phase_q && (slot_q < {1'b0, code_q});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic on_q;
  assign on_q = (state_q == ST_RUN) || (state_q == ST_MUTE) || (state_q == ST_OVR);
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ind_out       <= '0;
      mute_lamp_out <= 1'b0;
    end else begin
      ind_out.relay_a     <= on_q;
      ind_out.relay_b     <= on_q;
      ind_out.led_relay_a <= on_q;
      ind_out.led_relay_b <= on_q;
      ind_out.led_ch2     <= (state_q == ST_SPECIAL) ? code_lit_q : 1'b1;
      case (state_q)
        ST_RUN, ST_MUTE: ind_out.led_ch1 <= 1'b1;
        ST_OVR:  ind_out.led_ch1 <= 1'b1;
        ST_WAIT: ind_out.led_ch1 <= slow_tgl_q;
        ST_BLOCK: ind_out.led_ch1 <= (start_btn_in && muting_q && mute_pair) ? fast_tgl_q
                                                                          : code_lit_q;
        ST_SPECIAL: ind_out.led_ch1 <= code_lit_q;
        default: ind_out.led_ch1 <= 1'b0;
      endcase
      ind_out.fault_lamp <= (state_q == ST_SPECIAL) ? 1'b0 :
                            (state_q == ST_MUTE) ? 1'b1 :
                            (state_q == ST_BLOCK) ? code_lit_q : 1'b0;
      ind_out.wait_lamp  <= (state_q == ST_WAIT) ? 1'b1 :
                            (state_q == ST_BLOCK) ? slow_tgl_q : 1'b0;
      mute_lamp_out <= (state_q == ST_MUTE) ? 1'b1 :
                       (state_q == ST_BLOCK && muting_q && mute_pair) ? fast_tgl_q :
                       (state_q == ST_BLOCK && code_q == CODE_MUTE) ? code_lit_q : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_relay_pair;
    @(posedge core_clk_in) disable iff (!rst_n_in) ind_out.relay_a == ind_out.relay_b;
  endproperty
  a_relay_pair: assert property (p_relay_pair) else $error("relays disagree");

  property p_leds_follow;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      ind_out.led_relay_a == ind_out.relay_a && ind_out.led_relay_b == ind_out.relay_b;
  endproperty
  a_leds_follow: assert property (p_leds_follow) else $error("relay led mismatch");

  property p_stop_fast;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_q == ST_RUN && !curtain_clear_in[1]) |=> ##1 !ind_out.relay_a;
  endproperty
  a_stop_fast: assert property (p_stop_fast) else $error("relay late to open");

  property p_special_off;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      special |=> ##1 (!ind_out.relay_a && !ind_out.fault_lamp && !ind_out.wait_lamp);
  endproperty
  a_special_off: assert property (p_special_off) else $error("special not honoured");

  property p_no_auto_clear;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_q == ST_BLOCK && code_q == CODE_MUTE && !btn_rise && !special) |=>
        state_q inside {ST_BLOCK, ST_OVR};
  endproperty
  a_no_auto_clear: assert property (p_no_auto_clear) else $error("mute fault cleared");

  property p_ch2_on;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      $past(state_q) != ST_SPECIAL && state_q != ST_SPECIAL |-> ##1 ind_out.led_ch2;
  endproperty
  a_ch2_on: assert property (p_ch2_on) else $error("ch2 led dark");

  property p_wait_lamp;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_q == ST_WAIT && !special) |=> ind_out.wait_lamp;
  endproperty
  a_wait_lamp: assert property (p_wait_lamp) else $error("wait lamp dark");

  property p_mute_lamp;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      state_q == ST_MUTE |=> (mute_lamp_out && ind_out.fault_lamp);
  endproperty
  a_mute_lamp: assert property (p_mute_lamp) else $error("muting lamp off");

  property p_ovr_bound;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      state_q == ST_OVR |-> ovr_cnt_q <= OVR_MAX_CYC;
  endproperty
  a_ovr_bound: assert property (p_ovr_bound) else $error("override too long");

  c_mute: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) state_q == ST_MUTE);
  c_ovr: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) state_q == ST_OVR);
  c_fail4: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
                           code_q == CODE_MUTE);
  c_run: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) state_q == ST_RUN);
endmodule

/* File: bench/field_model.sv */
// field model: light curtains, muting sensors, start button and muting lamp
module field_model (
  // clock
  input  wire logic       core_clk_in,
  // field lines toward the sequencer
  output logic [2:0]      curtain_clear_out,
  output logic [3:0]      mute_sensor_out,
  output logic            start_btn_out,
  output logic            mute_lamp_ok_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    curtain_clear_out = 3'h7;
    mute_sensor_out   = 4'h0;
    start_btn_out     = 1'b0;
    mute_lamp_ok_out  = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic set_curtain(input int idx, input logic clear);
    @(posedge core_clk_in);
    curtain_clear_out[idx] <= clear;
  endtask

  task automatic set_sensors(input logic [3:0] v);
    @(posedge core_clk_in);
    mute_sensor_out <= v;
  endtask

  task automatic set_lamp(input logic ok);
    @(posedge core_clk_in);
    mute_lamp_ok_out <= ok;
  endtask

  // a press is a rising edge; the button is released before any next press
  task automatic press(input int hold);
    @(posedge core_clk_in);
    start_btn_out <= 1'b1;
    step(hold);
    start_btn_out <= 1'b0;
    step(4);
  endtask

  // material entering: sensors in fixed order, then the first curtain breaks
  task automatic material_in(input logic four, input logic good);
    set_sensors(4'h1);
    step(2);
    if (good) set_sensors(4'h3);
    step(2);
    if (four && good) set_sensors(4'h7);
    step(2);
    set_curtain(0, 1'b0);
    step(2);
  endtask

  // material leaving: curtain clears first, sensors drop afterwards
  task automatic material_out();
    set_curtain(0, 1'b1);
    step(2);
    set_sensors(4'h0);
    step(2);
  endtask
endmodule

/* File: bench/light_curtain_safety_sequencer_tb.sv */
// testbench: starts, feedback, config faults, voltage faults and muting
module light_curtain_safety_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import curtain_pkg::*;

  logic        core_clk;
  logic        rst_n;
  selector_t   sel;
  logic        feedback;
  logic        undervolt;
  logic        overvolt;
  logic [2:0]  curtain_clear;
  logic [3:0]  mute_sensor;
  logic        start_btn;
  logic        lamp_ok;
  indic_t      ind;
  logic        mute_lamp;
  int          n_errors;
  int          checks;
  int          cycles;

  light_curtain_safety_sequencer #(
    .MUTE_BASE_CYC (100)
  ) u_light_curtain_safety_sequencer (
    .core_clk_in        (core_clk),
    .rst_n_in           (rst_n),
    .sel_in             (sel),
    .curtain_clear_in   (curtain_clear),
    .mute_sensor_in     (mute_sensor),
    .start_btn_in       (start_btn),
    .feedback_closed_in (feedback),
    .mute_lamp_ok_in    (lamp_ok),
    .undervolt_in       (undervolt),
    .overvolt_in        (overvolt),
    .ind_out            (ind),
    .mute_lamp_out      (mute_lamp)
  );

  field_model u_field_model (
    .core_clk_in       (core_clk),
    .curtain_clear_out (curtain_clear),
    .mute_sensor_out   (mute_sensor),
    .start_btn_out     (start_btn),
    .mute_lamp_ok_out  (lamp_ok)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic end_of_test();
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the whole run takes about 1300 cycles; this ceiling catches a hang
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] rel();
    return {4'h0, ind.relay_a, ind.relay_b, ind.led_relay_a, ind.led_relay_b};
  endfunction

  // sample a little after the edge so the registered outputs have settled
  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // one selector feeds both channels, so they can never disagree
  task automatic restart(input logic [3:0] f, input logic [3:0] s);
    @(posedge core_clk);
    rst_n <= 1'b0;
    sel   <= {f, s};
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    look(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_power_up();
    restart(4'h1, 4'h1);
    check(rel(), 8'h00);
    check({7'h0, ind.led_ch2}, 8'h01);
    check({7'h0, ind.wait_lamp}, 8'h01);
    u_field_model.press(2);
    look(3);
    check(rel(), 8'h0f);
    check({7'h0, ind.wait_lamp}, 8'h00);
  endtask

  task automatic t_manual();
    u_field_model.set_curtain(1, 1'b0);
    look(3);
    check(rel(), 8'h00);
    u_field_model.set_curtain(1, 1'b1);
    look(6);
    check(rel(), 8'h00);
    u_field_model.press(2);
    look(3);
    check(rel(), 8'h0f);
  endtask

  task automatic t_auto();
    restart(4'h0, 4'h1);
    u_field_model.press(2);
    u_field_model.set_curtain(0, 1'b0);
    look(3);
    check(rel(), 8'h00);
    u_field_model.set_curtain(0, 1'b1);
    look(4);
    check(rel(), 8'h0f);
    u_field_model.set_curtain(1, 1'b0);
    u_field_model.set_curtain(0, 1'b0);
    u_field_model.set_curtain(0, 1'b1);
    look(4);
    check(rel(), 8'h00);
    u_field_model.set_curtain(1, 1'b1);
    look(4);
    check(rel(), 8'h00);
  endtask

  task automatic t_feedback();
    restart(4'h1, 4'h6);
    u_field_model.press(2);
    look(3);
    check(rel(), 8'h00);
    @(posedge core_clk);
    feedback <= 1'b1;
    u_field_model.press(2);
    look(3);
    check(rel(), 8'h0f);
    @(posedge core_clk);
    feedback <= 1'b0;
  endtask

  task automatic t_bad_config();
    logic [7:0] bad [4];
    bad = '{8'h10, 8'h14, 8'h19, 8'h60};
    foreach (bad[i]) begin
      restart(bad[i][7:4], bad[i][3:0]);
      u_field_model.press(2);
      look(3);
      check(rel(), 8'h00);
    end
  endtask

  task automatic t_voltage();
    for (int v = 0; v < 2; v++) begin
      restart(4'h1, 4'h1);
      u_field_model.press(2);
      @(posedge core_clk);
      undervolt <= (v == 0);
      overvolt  <= (v == 1);
      look(4);
      check(rel(), 8'h00);
      check({6'h0, ind.fault_lamp, ind.wait_lamp}, 8'h00);
      @(posedge core_clk);
      undervolt <= 1'b0;
      overvolt  <= 1'b0;
    end
  endtask

  task automatic t_muting();
    for (int f = 2; f <= 5; f++) begin
      restart(4'(f), 4'h0);
      u_field_model.press(2);
      u_field_model.material_in(f >= 4, 1'b1);
      look(1);
      check(rel(), 8'h0f);
      check({7'h0, ind.fault_lamp}, 8'h01);
      check({7'h0, mute_lamp}, 8'h01);
      u_field_model.material_out();
      look(2);
      check(rel(), 8'h0f);
      check({7'h0, mute_lamp}, 8'h00);
      u_field_model.material_in(f >= 4, 1'b1);
      look(150);
      check(rel(), 8'h00);
      u_field_model.press(2);
      look(3);
      check(rel(), 8'h00);
      u_field_model.material_out();
      look(20);
      check(rel(), 8'h00);
      u_field_model.press(2);
      look(3);
      check(rel(), 8'h0f);
    end
  endtask

  task automatic t_mute_faults();
    restart(4'h3, 4'h0);
    u_field_model.press(2);
    u_field_model.material_in(1'b0, 1'b0);
    look(1);
    check(rel(), 8'h00);
    u_field_model.material_out();
    u_field_model.set_lamp(1'b0);
    u_field_model.press(2);
    look(3);
    check(rel(), 8'h00);
    u_field_model.set_lamp(1'b1);
    u_field_model.press(2);
    u_field_model.material_in(1'b0, 1'b1);
    u_field_model.set_sensors(4'h1);
    look(4);
    check(rel(), 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_errors  = 0;
    checks    = 0;
    cycles    = 0;
    rst_n     = 1'b0;
    sel       = 8'h11;
    feedback  = 1'b0;
    undervolt = 1'b0;
    overvolt  = 1'b0;
    look(2);
    check(ind, 8'h00);
    t_power_up();
    t_manual();
    t_auto();
    t_feedback();
    t_bad_config();
    t_voltage();
    t_muting();
    t_mute_faults();
    end_of_test();
  end
endmodule
